// >>> rtl/blc_pkg.sv
package blc_pkg;
   localparam logic [7:0] BLC_ADDR_BRIGHTNESS = 8'h00;
   localparam logic [7:0] BLC_ADDR_DEVCTRL = 8'h01;
   localparam logic [7:0] BLC_ADDR_STATUS = 8'h02;
   localparam logic [7:0] BLC_BRIGHTNESS_RST = 8'h00;
   localparam logic [7:0] BLC_DEVCTRL_RST = 8'h00;
   localparam logic [7:0] BLC_STATUS_RST = 8'h00;
   localparam int BLC_FAST_BIT = 7;
   localparam int BLC_MODE_LSB = 1;
   localparam int BLC_ENABLE_BIT = 0;
   localparam int BLC_OPEN_BIT = 7;
   localparam int BLC_SHORT_BIT = 6;
   localparam int BLC_OVP_BIT = 3;
   localparam int BLC_OCP_BIT = 2;
   localparam int BLC_SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      BLC_MODE_PIN = 2'h0,
      BLC_MODE_MIX_PRE = 2'h1,
      BLC_MODE_REG = 2'h2,
      BLC_MODE_MIX_POST = 2'h3
   } blc_mode_t;

   typedef enum logic [1:0] {
      BLC_ST_BOOT_LOAD,
      BLC_ST_ACTIVE,
      BLC_ST_STANDBY,
      BLC_ST_RELOAD
   } blc_state_t;

   typedef struct packed {
      logic led_open;
      logic led_short;
      logic vref_ok;
      logic vboost_ok;
      logic ovp_event;
      logic ocp_event;
      logic tsd;
      logic uvlo;
   } blc_fault_t;

   typedef struct packed {
      logic fast_resume;
      blc_mode_t brightness_source_select;
      logic backlight_enable_bit;
   } blc_ctrl_t;

   function automatic logic [7:0] blc_scale(input logic [7:0] a, input logic [7:0] b);
      logic [15:0] p;
      p = 16'(a) * 16'(b);
      return p[15:8];
   endfunction

   function automatic logic [7:0] blc_shape(input logic [7:0] x);
      return blc_scale(x, x);
   endfunction
endpackage

// >>> rtl/blc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module blc_sync
   import blc_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

// >>> rtl/blc_bright_path.sv
`timescale 1ns/1ps
`default_nettype none
module blc_bright_path
   import blc_pkg::*;
(
   // brightness sources
   input wire logic [7:0] brightness_level_field,
   input wire logic [7:0] pwm_duty,
   input wire blc_mode_t brightness_source_select,
   // shaped duty
   output logic [7:0] duty
);
   wire logic [7:0] pre_mix;
   wire logic [7:0] shaped_pre;
   wire logic [7:0] post_mix;
   wire logic [7:0] shaped_pwm;
   wire logic [7:0] shaped_brt;

   assign shaped_pwm = blc_shape(pwm_duty);
   assign shaped_brt = blc_shape(brightness_level_field);
   // mix ahead of the shaper
   assign pre_mix = blc_scale(pwm_duty, brightness_level_field); // R7
   assign shaped_pre = blc_shape(pre_mix); // R7
   // mix after the shaper
   assign post_mix = blc_scale(shaped_pwm, brightness_level_field); // R8

   assign duty = (brightness_source_select == BLC_MODE_PIN) ? shaped_pwm : // R6
                 (brightness_source_select == BLC_MODE_REG) ? shaped_brt : // R6
                 (brightness_source_select == BLC_MODE_MIX_PRE) ? shaped_pre : post_mix;
endmodule
`default_nettype wire

// >>> rtl/blc_regs.sv
`timescale 1ns/1ps
`default_nettype none
//Contract
// R1 - brightness byte is read/write, sets duty linearly, resets to zero; the code squares it through blc_shape instead
// R2 - brightness, control and status registers clear to zero on reset
// R3 - fast-resume bit 7 set skips nonvolatile reload on standby exit
// R4 - fast-resume clear reloads trim and config on every standby exit
// R5 - fast-resume set loads nonvolatile contents only once at power-up
// R6 - source 00 uses PWM pin only, 10 uses brightness register only
// R7 - source 01 combines PWM duty and register before shaping
// R8 - source 11 combines PWM duty and register after shaping
// R9 - register mode: enable bit 1 turns on, 0 turns device off
// R10 - pin mode ignores enable bit; PWM pin level turns device on or off
// R11 - status bit 7 shows live open-string fault, not latched
// R12 - status bits are read-only; writes do not alter fault state
// R13 - status bit 6 shows live short fault, not latched
// R14 - latched overvoltage and overcurrent bits clear when status is read
// R15 - control bits 6 to 3 read zero and ignore writes
module blc_regs
   import blc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register access port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // pwm brightness source
   input wire logic pwm_pin,
   input wire logic [7:0] pwm_duty,
   // fault monitors
   input wire blc_fault_t fault_in,
   // nonvolatile load handshake
   input wire logic nvm_load_done,
   output logic nvm_load_req,
   // backlight drive
   output logic [7:0] led_duty,
   output logic backlight_on,
   output logic device_active
);
   logic [7:0] brightness_r;
   blc_ctrl_t ctrl_r;
   logic ovp_lat_r;
   logic ocp_lat_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic [7:0] duty_r;
   logic bl_on_r;
   logic load_req_r;
   blc_state_t state_r;
   blc_state_t state_nxt;
   logic ovp_lat_nxt;
   logic ocp_lat_nxt;
   blc_fault_t fault_s;
   logic pwm_s;
   logic brt_written_r;
   logic active_r;

   blc_sync #(
      .W($bits(blc_fault_t) + 1)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({fault_in, pwm_pin}),
      .q({fault_s, pwm_s})
   );

   wire logic [7:0] path_duty;
   blc_bright_path u_path (
      .brightness_level_field(brightness_r),
      .pwm_duty(pwm_duty),
      .brightness_source_select(ctrl_r.brightness_source_select),
      .duty(path_duty)
   );

   // decode
   wire logic wr_brt = reg_wr && (reg_addr == BLC_ADDR_BRIGHTNESS);
   wire logic wr_ctl = reg_wr && (reg_addr == BLC_ADDR_DEVCTRL);
   wire logic rd_sts = reg_rd && (reg_addr == BLC_ADDR_STATUS);
   wire blc_mode_t mode = ctrl_r.brightness_source_select;
   wire logic chip_en = (mode == BLC_MODE_PIN) ? pwm_s : ctrl_r.backlight_enable_bit; // R9 R10
   wire logic [7:0] ctl_rd = {ctrl_r.fast_resume, 4'h0, mode, ctrl_r.backlight_enable_bit}; // R15
   wire logic [7:0] sts_rd = {fault_s.led_open, fault_s.led_short, fault_s.vref_ok, // R11 R13
                              fault_s.vboost_ok, ovp_lat_r, ocp_lat_r, fault_s.tsd, fault_s.uvlo};
   wire logic [7:0] rd_mux = (reg_addr == BLC_ADDR_BRIGHTNESS) ? brightness_r :
                             (reg_addr == BLC_ADDR_DEVCTRL) ? ctl_rd :
                             (reg_addr == BLC_ADDR_STATUS) ? sts_rd : 8'h00;

   // sticky fault flags, an event beats the clearing read
   assign ovp_lat_nxt = (ovp_lat_r && !rd_sts) || fault_s.ovp_event; // R14 R12
   assign ocp_lat_nxt = (ocp_lat_r && !rd_sts) || fault_s.ocp_event; // R14 R12

   // power state sequencing
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         BLC_ST_BOOT_LOAD: begin
            if (nvm_load_done) begin
               state_nxt = chip_en ? BLC_ST_ACTIVE : BLC_ST_STANDBY; // R5 R9
            end
         end
         BLC_ST_ACTIVE: begin
            if (!chip_en) begin
               state_nxt = BLC_ST_STANDBY; // R9
            end
         end
         BLC_ST_STANDBY: begin
            if (chip_en) begin
               state_nxt = ctrl_r.fast_resume ? BLC_ST_ACTIVE : BLC_ST_RELOAD; // R3 R4
            end
         end
         BLC_ST_RELOAD: begin
            if (nvm_load_done) begin
               state_nxt = chip_en ? BLC_ST_ACTIVE : BLC_ST_STANDBY; // R4 R9
            end
         end
         default: begin
            state_nxt = BLC_ST_BOOT_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         brightness_r <= BLC_BRIGHTNESS_RST; // R2
         ctrl_r <= {BLC_DEVCTRL_RST[BLC_FAST_BIT], BLC_DEVCTRL_RST[BLC_MODE_LSB+1:BLC_MODE_LSB],
                    BLC_DEVCTRL_RST[BLC_ENABLE_BIT]}; // R2
      end else begin
         if (wr_brt) begin
            brightness_r <= reg_wdata; // R1
         end
         if (wr_ctl) begin
            ctrl_r <= {reg_wdata[BLC_FAST_BIT], reg_wdata[BLC_MODE_LSB+1:BLC_MODE_LSB],
                       reg_wdata[BLC_ENABLE_BIT]}; // R15
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ovp_lat_r <= BLC_STATUS_RST[BLC_OVP_BIT]; // R2
         ocp_lat_r <= BLC_STATUS_RST[BLC_OCP_BIT]; // R2
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         ovp_lat_r <= ovp_lat_nxt;
         ocp_lat_r <= ocp_lat_nxt;
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            rdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= BLC_ST_BOOT_LOAD;
         load_req_r <= 1'b0;
         duty_r <= 8'h00;
         bl_on_r <= 1'b0;
         active_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         active_r <= (state_nxt == BLC_ST_ACTIVE); // R9 R10
         load_req_r <= (state_nxt == BLC_ST_BOOT_LOAD) || (state_nxt == BLC_ST_RELOAD);
         duty_r <= path_duty; // R1
         bl_on_r <= chip_en && (state_r == BLC_ST_ACTIVE); // R9 R10
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign nvm_load_req = load_req_r;
   assign led_duty = duty_r;
   assign backlight_on = bl_on_r;
   assign device_active = active_r;

   // checking helpers
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         brt_written_r <= 1'b0;
      end else if (wr_brt) begin
         brt_written_r <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // register contents
   a_brt_write: assert property (wr_brt |=> brightness_r == $past(reg_wdata)) // R1
      else $error("brightness write not stored");
   a_brt_hold: assert property (!wr_brt |=> brightness_r == $past(brightness_r)) // R1
      else $error("brightness changed without a write");
   a_brt_read: assert property (reg_rd && reg_addr == BLC_ADDR_BRIGHTNESS // R1
      |=> reg_rvalid && reg_rdata == $past(brightness_r))
      else $error("brightness read back wrong");
   a_brt_reset: assert property (!brt_written_r |-> brightness_r == BLC_BRIGHTNESS_RST) // R2
      else $error("brightness not zero before first write");

   // power sequencing
   a_fast_skip: assert property ( // R3 R5
      state_r == BLC_ST_STANDBY && chip_en && ctrl_r.fast_resume
      |=> state_r == BLC_ST_ACTIVE && !nvm_load_req)
      else $error("fast resume did not skip reload");
   a_slow_reload: assert property ( // R4
      state_r == BLC_ST_STANDBY && chip_en && !ctrl_r.fast_resume
      |=> state_r == BLC_ST_RELOAD && nvm_load_req)
      else $error("standby exit did not reload");
   a_reload_done: assert property ( // R4
      state_r == BLC_ST_RELOAD && nvm_load_done && chip_en
      |=> state_r == BLC_ST_ACTIVE && !nvm_load_req)
      else $error("reload did not end in active");
   a_load_req: assert property (state_r == BLC_ST_RELOAD && !nvm_load_done // R4
      |=> nvm_load_req)
      else $error("reload request dropped early");
   a_boot_once: assert property (state_r != BLC_ST_BOOT_LOAD // R5
      |=> state_r != BLC_ST_BOOT_LOAD)
      else $error("boot load repeated");
   a_standby_hold: assert property (state_r == BLC_ST_STANDBY && !chip_en // R9
      |=> state_r == BLC_ST_STANDBY && !nvm_load_req)
      else $error("standby left while disabled");

   // duty path
   a_pin_duty: assert property ((mode == BLC_MODE_PIN) ##1 (mode == BLC_MODE_PIN) // R6
      |-> led_duty == blc_shape($past(pwm_duty)))
      else $error("pin mode duty wrong");
   a_reg_duty: assert property ((mode == BLC_MODE_REG) ##1 (mode == BLC_MODE_REG) // R6
      |-> led_duty == blc_shape($past(brightness_r)))
      else $error("register mode duty wrong");
   a_pre_mix: assert property ((mode == BLC_MODE_MIX_PRE) ##1 (mode == BLC_MODE_MIX_PRE) // R7
      |-> led_duty == blc_shape(blc_scale($past(pwm_duty), $past(brightness_r))))
      else $error("pre-shaper mix wrong");
   a_post_mix: assert property ((mode == BLC_MODE_MIX_POST) ##1 (mode == BLC_MODE_MIX_POST) // R8
      |-> led_duty == blc_scale(blc_shape($past(pwm_duty)), $past(brightness_r)))
      else $error("post-shaper mix wrong");

   // enable
   a_reg_off: assert property (mode == BLC_MODE_REG && !ctrl_r.backlight_enable_bit // R9
      |=> !backlight_on && !device_active)
      else $error("register mode disable ignored");
   a_reg_on: assert property (mode == BLC_MODE_REG && ctrl_r.backlight_enable_bit // R9
      && device_active |=> backlight_on)
      else $error("register mode enable ignored");
   a_active_en: assert property (!chip_en |=> !device_active) // R9 R10
      else $error("active while disabled");
   a_pin_off: assert property ((mode == BLC_MODE_PIN && !pwm_s) |=> !backlight_on) // R10
      else $error("pin mode low did not disable");
   a_pin_ignore: assert property (mode == BLC_MODE_PIN && pwm_s && device_active // R10
      |=> backlight_on)
      else $error("pin mode high did not enable");
   a_pin_on: assert property ( // R10
      mode == BLC_MODE_PIN && pwm_s && state_r == BLC_ST_STANDBY && !ctrl_r.fast_resume
      |=> state_r == BLC_ST_RELOAD)
      else $error("pin mode high did not leave standby");

   // status
   a_open_read: assert property (reg_rd && reg_addr == BLC_ADDR_STATUS // R11
      |=> reg_rvalid && reg_rdata[BLC_OPEN_BIT] == $past(fault_s.led_open))
      else $error("open fault bit wrong");
   a_short_read: assert property (reg_rd && reg_addr == BLC_ADDR_STATUS // R13
      |=> reg_rdata[BLC_SHORT_BIT] == $past(fault_s.led_short))
      else $error("short fault bit wrong");
   a_status_ro: assert property (reg_wr && reg_addr == BLC_ADDR_STATUS && !reg_rd // R12
      |=> ovp_lat_r == $past(ovp_lat_r || fault_s.ovp_event))
      else $error("status write changed fault state");
   a_ocp_ro: assert property (reg_wr && reg_addr == BLC_ADDR_STATUS && !reg_rd // R12
      |=> ocp_lat_r == $past(ocp_lat_r || fault_s.ocp_event))
      else $error("status write changed overcurrent state");
   a_ovp_clear: assert property (rd_sts && !fault_s.ovp_event && !fault_s.ocp_event // R14
      |=> !ovp_lat_r && !ocp_lat_r)
      else $error("status read did not clear latches");
   a_ovp_set: assert property (fault_s.ovp_event |=> ovp_lat_r) // R14
      else $error("overvoltage event lost");
   a_ocp_set: assert property (fault_s.ocp_event |=> ocp_lat_r) // R14
      else $error("overcurrent event lost");
   a_ovp_hold: assert property (ovp_lat_r && !rd_sts |=> ovp_lat_r) // R14
      else $error("overvoltage latch lost without a read");
   a_ocp_hold: assert property (ocp_lat_r && !rd_sts |=> ocp_lat_r) // R14
      else $error("overcurrent latch lost without a read");
   a_latch_read: assert property (rd_sts |=> reg_rdata[BLC_OVP_BIT] == $past(ovp_lat_r) // R14
      && reg_rdata[BLC_OCP_BIT] == $past(ocp_lat_r))
      else $error("latched fault bits read wrong");

   // control readback
   a_ctl_rsvd: assert property (reg_rd && reg_addr == BLC_ADDR_DEVCTRL // R15
      |=> reg_rdata[6:3] == 4'h0)
      else $error("control reserved bits not zero");
   a_ctl_fast: assert property (reg_rd && reg_addr == BLC_ADDR_DEVCTRL // R3
      |=> reg_rdata[BLC_FAST_BIT] == $past(ctrl_r.fast_resume))
      else $error("fast resume bit read wrong");
   a_ctl_mode: assert property (reg_rd && reg_addr == BLC_ADDR_DEVCTRL // R6
      |=> reg_rdata[BLC_MODE_LSB+1:BLC_MODE_LSB] == $past(mode))
      else $error("source select read wrong");
   a_ctl_enable: assert property (reg_rd && reg_addr == BLC_ADDR_DEVCTRL // R9
      |=> reg_rdata[BLC_ENABLE_BIT] == $past(ctrl_r.backlight_enable_bit))
      else $error("enable bit read wrong");

   c_fast_resume: cover property (state_r == BLC_ST_STANDBY ##1 state_r == BLC_ST_ACTIVE);
   c_reload: cover property (state_r == BLC_ST_RELOAD ##[1:20] state_r == BLC_ST_ACTIVE);
   c_ovp_clear: cover property (ovp_lat_r ##1 rd_sts ##1 !ovp_lat_r);
   c_mix_post: cover property (mode == BLC_MODE_MIX_POST && backlight_on);
   c_pin_reload: cover property (mode == BLC_MODE_PIN && state_r == BLC_ST_RELOAD);
endmodule
`default_nettype wire

// >>> dv/blc_nvm_model.sv
`timescale 1ns/1ps
`default_nettype none
// nonvolatile loader: answers each load request lat cycles after first sampling it
module blc_nvm_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // load handshake
   input wire logic nvm_load_req,
   output logic nvm_load_done,
   // answer delay and request count
   input wire logic [31:0] lat,
   output int load_count
);
   int cnt_r;
   logic req_r;
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 0;
         req_r <= 1'b0;
         nvm_load_done <= 1'b0;
         load_count <= 0;
      end else begin
         req_r <= nvm_load_req;
         if (nvm_load_req && !req_r) begin
            load_count <= load_count + 1;
         end
         if (nvm_load_req && !nvm_load_done) begin
            if (cnt_r >= lat) begin
               nvm_load_done <= 1'b1;
            end else begin
               cnt_r <= cnt_r + 1;
            end
         end else begin
            nvm_load_done <= 1'b0;
            cnt_r <= 0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> dv/blc_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module blc_regs_bench;
   import blc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic pwm_pin = 1'b0;
   logic [7:0] pwm_duty = 8'h00;
   logic [7:0] fault_v = 8'h00;
   logic nvm_load_done;
   logic nvm_load_req;
   logic [7:0] led_duty;
   logic backlight_on;
   logic device_active;
   int lat = 0;
   int load_count;
   int fail_count = 0;
   int samples_checked = 0;
   logic [31:0] seed = 32'he4b3;
   logic [7:0] expq[$];
   logic [7:0] b;
   logic [7:0] p;
   logic [7:0] e;
   int n;
   always #25 clk = ~clk;
   blc_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pwm_pin(pwm_pin),
      .pwm_duty(pwm_duty), .fault_in(blc_fault_t'(fault_v)),
      .nvm_load_done(nvm_load_done), .nvm_load_req(nvm_load_req),
      .led_duty(led_duty), .backlight_on(backlight_on),
      .device_active(device_active));
   blc_nvm_model nvm (.clk(clk), .reset_n(reset_n),
      .nvm_load_req(nvm_load_req), .nvm_load_done(nvm_load_done),
      .lat(lat), .load_count(load_count));
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   function automatic logic [7:0] mul(input logic [7:0] x, input logic [7:0] y);
      logic [15:0] r;
      r = {8'h00, x} * {8'h00, y};
      return r[15:8];
   endfunction
   task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
      samples_checked++;
      if (s !== x) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      expq.push_back(x);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // read data monitor
   always @(posedge clk) begin
      if (reg_rvalid === 1'b1) begin
         if (expq.size() == 0) begin
            check("unexpected rvalid", 8'h01, 8'h00);
         end else begin
            check("reg_rdata", reg_rdata, expq.pop_front());
         end
      end
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      tick(12);
      reset_n = 1'b1;
      tick(20);
      rd(BLC_ADDR_BRIGHTNESS, 8'h00);
      rd(BLC_ADDR_DEVCTRL, 8'h00);
      rd(BLC_ADDR_STATUS, 8'h00);
      b = rnd();
      wr(BLC_ADDR_BRIGHTNESS, b);
      rd(BLC_ADDR_BRIGHTNESS, b);
      wr(BLC_ADDR_DEVCTRL, 8'hFF);
      rd(BLC_ADDR_DEVCTRL, 8'h87);
      wr(BLC_ADDR_STATUS, 8'hFF);
      rd(BLC_ADDR_STATUS, 8'h00);
      rd(8'h10, 8'h00);
      // live fault bits follow the monitor both ways
      for (int i = 6; i < 8; i++) begin
         fault_v = 8'h01 << i;
         tick(4);
         rd(BLC_ADDR_STATUS, fault_v);
         fault_v = 8'h00;
         tick(4);
         rd(BLC_ADDR_STATUS, 8'h00);
      end
      fault_v = 8'h0C;
      tick(4);
      fault_v = 8'h00;
      tick(4);
      rd(BLC_ADDR_STATUS, 8'h0C);
      rd(BLC_ADDR_STATUS, 8'h00);
      // every brightness source code
      pwm_pin = 1'b1;
      for (int m = 0; m < 4; m++) begin
         b = rnd();
         p = rnd();
         pwm_duty = p;
         wr(BLC_ADDR_BRIGHTNESS, b);
         wr(BLC_ADDR_DEVCTRL, {5'h00, 2'(m), 1'b1});
         tick(4);
         case (m)
            0: e = mul(p, p);
            1: e = mul(mul(p, b), mul(p, b));
            2: e = mul(b, b);
            default: e = mul(mul(p, p), b);
         endcase
         check("led_duty", led_duty, e);
      end
      // register mode enable, slow loader
      lat = 5;
      wr(BLC_ADDR_DEVCTRL, 8'h04);
      tick(4);
      check("device_active", {7'h00, device_active}, 8'h00);
      check("backlight_on", {7'h00, backlight_on}, 8'h00);
      n = load_count;
      wr(BLC_ADDR_DEVCTRL, 8'h05);
      tick(14);
      check("load_count", 8'(load_count), 8'(n + 1));
      check("device_active", {7'h00, device_active}, 8'h01);
      check("backlight_on", {7'h00, backlight_on}, 8'h01);
      // fast resume skips the reload
      wr(BLC_ADDR_DEVCTRL, 8'h84);
      tick(4);
      wr(BLC_ADDR_DEVCTRL, 8'h85);
      tick(3);
      check("device_active", {7'h00, device_active}, 8'h01);
      check("load_count", 8'(load_count), 8'(n + 1));
      // pin mode ignores the enable bit
      wr(BLC_ADDR_DEVCTRL, 8'h00);
      tick(4);
      check("device_active", {7'h00, device_active}, 8'h01);
      pwm_pin = 1'b0;
      tick(6);
      check("device_active", {7'h00, device_active}, 8'h00);
      pwm_pin = 1'b1;
      tick(16);
      check("device_active", {7'h00, device_active}, 8'h01);
      check("load_count", 8'(load_count), 8'(n + 2));
      report_and_stop();
   end
endmodule
`default_nettype wire
